// ===== rtl/stp_defs.vh
// Constants for the shared timer prescaler: register map, fields, codes.
// Included by every design file of the block; holds definitions only.
`ifndef STP_DEFS_VH
`define STP_DEFS_VH

`define STP_GTC_OFFSET      12'h000
`define STP_SEL0_OFFSET     12'h004
`define STP_SEL1_OFFSET     12'h008
`define STP_STAT_OFFSET     12'h00C

`define STP_GTC_RESET       8'h00
`define STP_GTC_HOLD_BIT    7
`define STP_GTC_PSR_BIT     0

`define STP_SEL_RESET       3'h0
`define STP_CS_STOP         3'h0
`define STP_CS_DIRECT       3'h1
`define STP_CS_DIV8         3'h2
`define STP_CS_DIV64        3'h3
`define STP_CS_DIV256       3'h4
`define STP_CS_DIV1024      3'h5
`define STP_CS_EXT_FALL     3'h6
`define STP_CS_EXT_RISE     3'h7

`define STP_DIV_WIDTH       10

`define STP_RESP_OKAY       2'h0
`define STP_RESP_SLVERR     2'h2

`endif

// ===== rtl/stp_pin_sync.v
// External clock pin sampler and edge detector for one timer.
// Assumes a pin input asynchronous to clk_i and one system clock.
`timescale 1ns/1ps
`include "stp_defs.vh"

module stp_pin_sync
(
  input  wire       clk_i,
  input  wire       srst_i,
  input  wire       pin_i,
  output wire       rise_o,
  output wire       fall_o
);

  reg  latch_r;
  reg  sync_r;
  reg  sync2_r;
  reg  prev_r;

  // Stands in for a latch open while the clock is high: a falling-edge flop
  // holds the same value at the next rising edge without a sampling race,
  // and gives the half-cycle of the 2.5 to 3.5 cycle latency
  always @(negedge clk_i)
  begin
    if (srst_i)
      latch_r <= 1'b0;
    else
      latch_r <= pin_i; // see RULE8, see RULE10
  end

  // Three rising-edge flops after the latch; only sync2 and prev are compared
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sync_r  <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end
    else
    begin
      sync_r  <= latch_r; // see RULE7
      sync2_r <= sync_r;
      prev_r  <= sync2_r;
    end
  end

  assign rise_o = sync2_r & ~prev_r; // see RULE9
  assign fall_o = ~sync2_r & prev_r; // see RULE9

endmodule // stp_pin_sync

// ===== rtl/stp_tick_mux.v
// Tick source selector for one timer.
// Assumes strobes and pin edges are one-cycle pulses on the same clock.
`timescale 1ns/1ps
`include "stp_defs.vh"

module stp_tick_mux
(
  input  wire [2:0] sel_i,
  input  wire       tap8_i,
  input  wire       tap64_i,
  input  wire       tap256_i,
  input  wire       tap1024_i,
  input  wire       rise_i,
  input  wire       fall_i,
  output reg        tick_o
);

  always @*
  begin
    case (sel_i)
      `STP_CS_STOP:     tick_o = 1'b0;       // see RULE18
      `STP_CS_DIRECT:   tick_o = 1'b1;       // see RULE1
      `STP_CS_DIV8:     tick_o = tap8_i;     // see RULE2
      `STP_CS_DIV64:    tick_o = tap64_i;    // see RULE2
      `STP_CS_DIV256:   tick_o = tap256_i;   // see RULE2
      `STP_CS_DIV1024:  tick_o = tap1024_i;  // see RULE2
      `STP_CS_EXT_FALL: tick_o = fall_i;     // see RULE9, see RULE13
      default:          tick_o = rise_i;     // see RULE9, see RULE13
    endcase
  end

endmodule // stp_tick_mux

// ===== rtl/stp_prescaler.v
// Shared prescaler for two timers with AXI4-Lite control registers.
// Assumes an AXI4-Lite master on ref_clk_i and external pins from off chip.
`timescale 1ns/1ps
`include "stp_defs.vh"

// What this block does
// RULE1 - Select one ticks every system clock
// RULE2 - Taps divide by 8, 64, 256, 1024
// RULE3 - One free-running divider shared by both
// RULE4 - Each timer has its own select
// RULE5 - First prescaled tick within 1 to N+1
// RULE6 - Divider reset restarts every timer's period
// RULE7 - Pins sampled each clock, then edge-detected
// RULE8 - High-transparent latch then rising-edge flops
// RULE9 - One tick per rising/falling edge, codes 7/6
// RULE10 - Pin edge to tick 2.5-3.5 clocks
// RULE11 - Change external select only with stable pin
// RULE12 - External clock below half system rate
// RULE13 - External ticks bypass the divider
// RULE14 - Reset bit self-clears unless hold set
// RULE15 - Hold bit keeps reset bit as written
// RULE16 - Clearing hold clears reset bit
// RULE17 - Bits 6..1 read zero; resets zero
// RULE18 - Select zero gives no ticks
// RULE19 - Ten-bit counter, cleared by resets
module stp_prescaler
#(
  parameter DIV_WIDTH = `STP_DIV_WIDTH
)
(
  input  wire        ref_clk_i,
  input  wire        srst_i,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        counter0_ext_clock_pin_i,
  input  wire        counter1_ext_clock_pin_i,
  output wire        counter0_tick_o,
  output wire        counter1_tick_o,
  output wire        prescaler_reset_o
);

  reg  [DIV_WIDTH-1:0] div_r;
  reg                  hold_r;
  reg                  psr_r;
  reg  [2:0]           sel0_r;
  reg  [2:0]           sel1_r;
  reg  [11:0]          awaddr_r;
  reg                  aw_full_r;
  reg  [31:0]          wdata_r;
  reg  [3:0]           wstrb_r;
  reg                  w_full_r;
  wire                 wr_go;
  wire                 wr_en;
  wire                 rd_go;
  wire                 tap8;
  wire                 tap64;
  wire                 tap256;
  wire                 tap1024;
  wire                 rise0;
  wire                 fall0;
  wire                 rise1;
  wire                 fall1;
  reg  [31:0]          rd_val;
  reg                  rd_ok;
  reg                  wr_gtc;
  reg                  wr_sel0;
  reg                  wr_sel1;
  reg                  wr_map;
  reg                  hold_nxt;
  reg                  psr_nxt;

  // Divider: free runs regardless of either select, held clear while the
  // reset bit stands, so both timers see the same restarted period
  always @(posedge ref_clk_i)
  begin
    if (srst_i || psr_r)
      div_r <= {DIV_WIDTH{1'b0}}; // see RULE19, see RULE6
    else
      div_r <= div_r + {{(DIV_WIDTH-1){1'b0}}, 1'b1}; // see RULE3
  end

  // Strobe when the low bits wrap; free-running taps give the 1..N+1 wait
  assign tap8    = ~psr_r & (div_r[2:0] == 3'h7);                // see RULE5
  assign tap64   = ~psr_r & (div_r[5:0] == 6'h3F);               // see RULE2
  assign tap256  = ~psr_r & (div_r[7:0] == 8'hFF);               // see RULE2
  assign tap1024 = ~psr_r & (div_r[DIV_WIDTH-1:0] == {DIV_WIDTH{1'b1}}); // see RULE2

  assign prescaler_reset_o = psr_r;

  // Pin edges feed the selectors directly; the reset bit does not gate them,
  // so an external count keeps running while the divider is held
  stp_pin_sync u_sync0
  (
    .clk_i  (ref_clk_i),
    .srst_i (srst_i),
    .pin_i  (counter0_ext_clock_pin_i),
    .rise_o (rise0),
    .fall_o (fall0)
  );

  stp_pin_sync u_sync1
  (
    .clk_i  (ref_clk_i),
    .srst_i (srst_i),
    .pin_i  (counter1_ext_clock_pin_i),
    .rise_o (rise1),
    .fall_o (fall1)
  );

  // Each timer its own selector on the shared taps
  stp_tick_mux u_mux0
  (
    .sel_i     (sel0_r), // see RULE4
    .tap8_i    (tap8),
    .tap64_i   (tap64),
    .tap256_i  (tap256),
    .tap1024_i (tap1024),
    .rise_i    (rise0),
    .fall_i    (fall0),
    .tick_o    (counter0_tick_o)
  );

  stp_tick_mux u_mux1
  (
    .sel_i     (sel1_r), // see RULE4
    .tap8_i    (tap8),
    .tap64_i   (tap64),
    .tap256_i  (tap256),
    .tap1024_i (tap1024),
    .rise_i    (rise1),
    .fall_i    (fall1),
    .tick_o    (counter1_tick_o)
  );

  // AXI4-Lite write: address and data captured in either order
  assign s_axi_awready = ~aw_full_r;
  assign s_axi_wready  = ~w_full_r;
  assign wr_go         = aw_full_r & w_full_r & ~s_axi_bvalid;
  assign wr_en         = wr_go & wstrb_r[0];

  always @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      aw_full_r <= 1'b0;
      awaddr_r  <= 12'h000;
    end
    else if (wr_go)
      aw_full_r <= 1'b0;
    else if (s_axi_awvalid && !aw_full_r)
    begin
      aw_full_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end
  end

  always @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      w_full_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end
    else if (wr_go)
      w_full_r <= 1'b0;
    else if (s_axi_wvalid && !w_full_r)
    begin
      w_full_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end
  end

  // Response waits for both halves and for the previous answer to drain
  always @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `STP_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_map ? `STP_RESP_OKAY : `STP_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Write decode on the held word address; the low two bits are ignored
  always @*
  begin
    wr_gtc  = 1'b0;
    wr_sel0 = 1'b0;
    wr_sel1 = 1'b0;
    wr_map  = 1'b1;
    if ({awaddr_r[11:2], 2'b00} == `STP_GTC_OFFSET)
      wr_gtc = 1'b1;
    else if ({awaddr_r[11:2], 2'b00} == `STP_SEL0_OFFSET)
      wr_sel0 = 1'b1;
    else if ({awaddr_r[11:2], 2'b00} == `STP_SEL1_OFFSET)
      wr_sel1 = 1'b1;
    else if ({awaddr_r[11:2], 2'b00} != `STP_STAT_OFFSET)
      wr_map = 1'b0;
  end

  // Next control state; a write in the same cycle wins over the self-clear
  always @*
  begin
    hold_nxt = hold_r;
    psr_nxt  = psr_r & hold_r; // see RULE14
    if (wr_en && wr_gtc)
    begin
      hold_nxt = wdata_r[`STP_GTC_HOLD_BIT]; // see RULE15
      // Writing hold to zero while hold is set releases the reset bit together
      if (!wdata_r[`STP_GTC_HOLD_BIT])
        psr_nxt = wdata_r[`STP_GTC_PSR_BIT] & ~hold_r; // see RULE16
      else
        psr_nxt = wdata_r[`STP_GTC_PSR_BIT]; // see RULE15
    end
  end

  // Control register and selects
  always @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      hold_r <= 1'b0; // see RULE17
      psr_r  <= 1'b0;
      sel0_r <= `STP_SEL_RESET;
      sel1_r <= `STP_SEL_RESET;
    end
    else
    begin
      hold_r <= hold_nxt;
      psr_r  <= psr_nxt;
      if (wr_en && wr_sel0)
        sel0_r <= wdata_r[2:0]; // see RULE4
      if (wr_en && wr_sel1)
        sel1_r <= wdata_r[2:0]; // see RULE4
    end
  end

  // Read decode
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_go         = s_axi_arvalid & ~s_axi_rvalid;

  always @*
  begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (s_axi_araddr[11:2] == `STP_GTC_OFFSET >> 2)
      rd_val = {24'h000000, hold_r, 6'h00, psr_r}; // see RULE17
    else if (s_axi_araddr[11:2] == `STP_SEL0_OFFSET >> 2)
      rd_val = {29'h00000000, sel0_r};
    else if (s_axi_araddr[11:2] == `STP_SEL1_OFFSET >> 2)
      rd_val = {29'h00000000, sel1_r};
    else if (s_axi_araddr[11:2] == `STP_STAT_OFFSET >> 2)
      rd_val = {{(32-DIV_WIDTH){1'b0}}, div_r};
    else
      rd_ok = 1'b0;
  end

  always @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `STP_RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_ok ? `STP_RESP_OKAY : `STP_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // stp_prescaler

// ===== verif/stp_prescaler_sva.sv
// Checker for the shared prescaler: bus answers, read fields, ticks.
// Bound to stp_prescaler; sees its ports only.
`timescale 1ns/1ps
module stp_prescaler_sva
(
  input wire        ref_clk_i,
  input wire        srst_i,
  input wire [11:0] s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        counter0_tick_o,
  input wire        counter1_tick_o
);
  reg  [11:0] wa_r;
  reg  [11:0] ra_r;
  wire        w_bad = wa_r[11:2] > 10'h003;
  wire        r_bad = ra_r[11:2] > 10'h003;
  // Addresses stay put until the answer rises: a new read waits for the answer, a new write address only for the write to go
  always @(posedge ref_clk_i)
  begin
    if (s_axi_awvalid && s_axi_awready) wa_r <= s_axi_awaddr;
    if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (wr_both |=> ##1 s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_arready_free: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  a_reserved_zero: assert property (s_axi_rvalid && ra_r == 12'h000 |-> (s_axi_rdata & 32'hFFFFFF7E) == 32'h0)
    else $error("reserved control bits set");
  a_read_slverr: assert property ($rose(s_axi_rvalid) |-> s_axi_rresp == (r_bad ? 2'h2 : 2'h0) && (!r_bad || s_axi_rdata == 32'h0))
    else $error("read response wrong");
  a_write_slverr: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp == (w_bad ? 2'h2 : 2'h0))
    else $error("write response wrong");
  a_idle_reset: assert property ($fell(srst_i) |-> !s_axi_bvalid && !s_axi_rvalid && !counter0_tick_o && !counter1_tick_o)
    else $error("not idle after reset");
endmodule // stp_prescaler_sva

bind stp_prescaler stp_prescaler_sva chk (.*);

// ===== verif/stp_ext_src.sv
// External clock source model for one timer pin.
// Assumes half_i of two or more system cycles per half period.
`timescale 1ns/1ps
module stp_ext_src
(
  input  wire       clk_i,
  input  wire       run_i,
  input  wire [7:0] half_i,
  output reg        pin_o
);
  reg [7:0] cnt_r = 8'h00;
  initial pin_o = 1'h0;
  // Pin moves 3 ns after an edge, as an unrelated source would
  always @(posedge clk_i)
  begin
    if (!run_i) cnt_r <= 8'h00;
    else if (cnt_r == half_i - 8'h01)
    begin
      cnt_r <= 8'h00;
      pin_o <= #3 ~pin_o;
    end
    else cnt_r <= cnt_r + 8'h01;
  end
endmodule // stp_ext_src

// ===== verif/tb_top.sv
// Self-checking bench for the shared timer prescaler.
// Assumes stp_prescaler, its checker and the external clock source model.
`timescale 1ns/1ps
`include "stp_defs.vh"
module tb_top;
  reg         ref_clk_i = 1'h0;
  reg         srst_i = 1'h1;
  reg  [11:0] s_axi_awaddr = 12'h000;
  reg         s_axi_awvalid = 1'h0;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg  [3:0]  s_axi_wstrb = 4'hF;
  reg         s_axi_wvalid = 1'h0;
  reg         s_axi_bready = 1'h1;
  reg  [11:0] s_axi_araddr = 12'h000;
  reg         s_axi_arvalid = 1'h0;
  reg         s_axi_rready = 1'h1;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        counter0_ext_clock_pin_i, counter1_ext_clock_pin_i;
  wire        counter0_tick_o, counter1_tick_o, prescaler_reset_o;
  reg  [1:0]  run = 2'h0;
  reg         ha, hw, hb;
  reg  [1:0]  hr;
  reg  [31:0] rd;
  integer     miscompares = 0;
  integer     checked = 0;
  integer     cyc = 0;
  integer     n0 = 0;
  integer     n1 = 0;
  integer     np = 0;
  integer     i;
  time        tp;

  stp_prescaler dut (.*);
  stp_ext_src src0 (.clk_i(ref_clk_i), .run_i(run[0]), .half_i(8'h03),
                    .pin_o(counter0_ext_clock_pin_i));
  stp_ext_src src1 (.clk_i(ref_clk_i), .run_i(run[1]), .half_i(8'h03),
                    .pin_o(counter1_ext_clock_pin_i));

  always #4 ref_clk_i = ~ref_clk_i;

  task wrap_up;
  begin
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask

  // Handshakes are judged at the falling edge, where all is settled
  task wr(input [11:0] a, input [31:0] d, input [1:0] r);
  begin
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do
    begin
      @(negedge ref_clk_i);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid;
      hr = s_axi_bresp;
      @(posedge ref_clk_i);
      if (ha) s_axi_awvalid <= 1'h0;
      if (hw) s_axi_wvalid <= 1'h0;
    end while (!hb);
    chk({30'h0, hr}, {30'h0, r});
  end
  endtask

  task rd_chk(input [11:0] a, input [31:0] e, input [1:0] r);
  begin
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do
    begin
      @(negedge ref_clk_i);
      ha = s_axi_arvalid & s_axi_arready;
      hb = s_axi_rvalid;
      rd = s_axi_rdata;
      hr = s_axi_rresp;
      @(posedge ref_clk_i);
      if (ha) s_axi_arvalid <= 1'h0;
    end while (!hb);
    chk(rd, e);
    chk({30'h0, hr}, {30'h0, r});
  end
  endtask

  task win(input integer c, input integer e0, input integer e1);
  begin
    n0 = 0;
    n1 = 0;
    repeat (c) @(posedge ref_clk_i);
    chk(n0, e0);
    chk(n1, e1);
  end
  endtask

  // Divider restarted at the last control write: nothing for 990 cycles, then one tick in the next 40
  task restart;
  begin
    rd_chk(`STP_GTC_OFFSET, 32'h0, 2'h0);
    win(990, 0, 0);
    win(40, 1, 1);
  end
  endtask

  function integer ex(input integer c);
    ex = (c == 0) ? 0 : 1024 >> (c == 1 ? 0 : c == 2 ? 3 : c == 3 ? 6 : c * 2);
  endfunction

  always @(negedge ref_clk_i)
  begin
    n0 <= n0 + counter0_tick_o;
    n1 <= n1 + counter1_tick_o;
    np <= np + prescaler_reset_o;
  end

  always @(posedge counter0_ext_clock_pin_i)
  begin
    tp = $time;
    while (counter0_tick_o !== 1'h1) @(negedge ref_clk_i);
    chk($time + 4 - tp >= 20 && $time + 4 - tp <= 28, 1);
  end

  always @(posedge ref_clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      miscompares = miscompares + 1;
      wrap_up;
    end
  end

  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    srst_i <= 1'h0;
    rd_chk(`STP_GTC_OFFSET, 32'h0, 2'h0);
    rd_chk(`STP_SEL1_OFFSET, 32'h0, 2'h0);
    rd_chk(12'h010, 32'h0, 2'h2);
    wr(12'h014, 32'h7, 2'h2);
    rd_chk(`STP_SEL0_OFFSET, 32'h0, 2'h0);
    for (i = 0; i < 6; i = i + 1)
    begin
      wr(`STP_SEL0_OFFSET, i, 2'h0);
      wr(`STP_SEL1_OFFSET, 5 - i, 2'h0);
      win(1024, ex(i), ex(5 - i));
    end
    wr(`STP_GTC_OFFSET, 32'hFF, 2'h0);
    rd_chk(`STP_GTC_OFFSET, 32'h81, 2'h0);
    wr(`STP_SEL0_OFFSET, 32'h2, 2'h0);
    wr(`STP_SEL1_OFFSET, 32'h3, 2'h0);
    win(200, 0, 0);
    rd_chk(`STP_STAT_OFFSET, 32'h0, 2'h0);
    wr(`STP_SEL0_OFFSET, 32'h7, 2'h0);
    wr(`STP_SEL1_OFFSET, 32'h6, 2'h0);
    fork
      run <= 2'h3;
      begin
        repeat (30) @(posedge ref_clk_i);
        run <= 2'h0;
      end
      win(38, 5, 5);
    join
    wr(`STP_SEL0_OFFSET, 32'h5, 2'h0);
    wr(`STP_SEL1_OFFSET, 32'h5, 2'h0);
    wr(`STP_GTC_OFFSET, 32'h0, 2'h0);
    restart;
    np = 0;
    wr(`STP_GTC_OFFSET, 32'h1, 2'h0);
    restart;
    chk(np, 1);
    wrap_up;
  end
endmodule // tb_top
